// ### src/sras_slave.sv
// register slave end: byte engine on the link clock, register image on system clock
`timescale 1ns/10ps
module sras_slave
  import sras_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_rst_async_n,
  input wire logic i_addr_select_low,
  input wire logic i_addr_select_high,
  input wire logic [7:0] i_status_data,
  sras_if.slave bus,
  output logic [7:0] o_wr_index,
  output logic [7:0] o_wr_data,
  output logic o_wr_pulse,
  output logic o_busy
);
  // link domain: clocked by scl (RULE_02); start/stop seen on sda edges
  logic start_tgl_reg, stop_tgl_reg;
  logic [1:0] sda_meta_reg;
  // start/stop detection needs sda as a clock; scl high marks the condition
  always_ff @(negedge bus.sda_in or negedge i_rst_async_n) begin
    if (!i_rst_async_n) begin
      start_tgl_reg <= 1'b0;
    end else if (bus.scl) begin
      start_tgl_reg <= ~start_tgl_reg;
    end
  end
  always_ff @(posedge bus.sda_in or negedge i_rst_async_n) begin
    if (!i_rst_async_n) begin
      stop_tgl_reg <= 1'b0;
    end else if (bus.scl) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end
  // seen-toggle copies in scl domain for framing
  logic start_seen_reg, start_seen_next;
  sras_state_t st_reg, st_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] idx_reg, idx_next;
  logic ack_drive_reg, ack_drive_next;
  logic ack_phase_reg, ack_phase_next;
  logic wtgl_reg, wtgl_next;
  logic [7:0] widx_reg, widx_next;
  logic [7:0] wdat_reg, wdat_next;
  logic [7:0] rd_byte;
  logic addr_ok;
  logic [7:0] regs [SRAS_REG_COUNT];
  logic [7:0] rd_byte_sys;

  assign addr_ok = sh_reg[6:0] == {SRAS_ADDR_HI, i_addr_select_high, SRAS_ADDR_MID,
    i_addr_select_low}; // RULE_03 RULE_08

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    idx_next = idx_reg;
    ack_drive_next = ack_drive_reg;
    ack_phase_next = ack_phase_reg;
    wtgl_next = wtgl_reg;
    widx_next = widx_reg;
    wdat_next = wdat_reg;
    start_seen_next = start_tgl_reg;
    if (start_seen_reg != start_tgl_reg) begin
      // new start (or repeated start) restarts framing; RULE_11 RULE_06
      st_next = SRAS_S_ADDR;
      bit_next = 3'h6;
      sh_next = {7'h00, bus.sda_in};
      ack_phase_next = 1'b0;
    end else if (ack_phase_reg) begin
      // the ack clock carries no data bit; the next byte starts at its top bit
      ack_phase_next = 1'b0;
      bit_next = 3'h7;
      if (st_reg == SRAS_S_RDATA && bus.sda_in) begin
        st_next = SRAS_S_IGNORE;
      end
    end else if (st_reg != SRAS_S_IDLE && st_reg != SRAS_S_IGNORE) begin
      sh_next = {sh_reg[6:0], bus.sda_in};
      if (bit_reg == 3'h0) begin
        ack_phase_next = 1'b1;
        // in a read the master acks the data bytes, so the slave keeps off the line
        ack_drive_next = st_reg != SRAS_S_RDATA;
        case (st_reg)
          SRAS_S_ADDR: begin
            if (addr_ok) begin
              st_next = bus.sda_in ? SRAS_S_RDATA : SRAS_S_INDEX; // RULE_07
            end else begin
              st_next = SRAS_S_IGNORE;
              ack_phase_next = 1'b0;
            end
          end
          SRAS_S_INDEX: begin
            idx_next = {sh_reg[6:0], bus.sda_in};
            st_next = SRAS_S_WDATA; // RULE_04
          end
          SRAS_S_WDATA: begin
            widx_next = idx_reg;
            wdat_next = {sh_reg[6:0], bus.sda_in};
            wtgl_next = ~wtgl_reg;
            idx_next = idx_reg + 8'h01; // RULE_05
          end
          SRAS_S_RDATA: begin
            idx_next = idx_reg + 8'h01; // RULE_07
          end
          default: begin
            st_next = SRAS_S_IGNORE;
          end
        endcase
      end else begin
        bit_next = bit_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge bus.scl or negedge i_rst_async_n) begin
    if (!i_rst_async_n) begin // RULE_09
      st_reg <= SRAS_S_IDLE;
      bit_reg <= 3'h7;
      sh_reg <= 8'h00;
      idx_reg <= 8'h00;
      ack_drive_reg <= 1'b0;
      ack_phase_reg <= 1'b0;
      wtgl_reg <= 1'b0;
      widx_reg <= 8'h00;
      wdat_reg <= 8'h00;
      start_seen_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      idx_reg <= idx_next;
      ack_drive_reg <= ack_drive_next;
      ack_phase_reg <= ack_phase_next;
      wtgl_reg <= wtgl_next;
      widx_reg <= widx_next;
      wdat_reg <= wdat_next;
      start_seen_reg <= start_seen_next;
    end
  end

  // data driven on falling scl, so the line only moves while scl is low
  logic sda_oe_n_reg, sda_oe_n_next;
  logic stop_seen_reg;
  logic [7:0] rd_sh_reg;
  always_comb begin
    sda_oe_n_next = 1'b1;
    if (ack_phase_reg) begin
      sda_oe_n_next = !ack_drive_reg;
    end else if (st_reg == SRAS_S_RDATA) begin
      sda_oe_n_next = rd_sh_reg[bit_reg]; // RULE_07
    end
  end
  // the read byte is sampled from the register image; rare tearing on a concurrent
  // status change is accepted rather than adding a word handshake
  assign rd_byte = rd_byte_sys;
  always_ff @(negedge bus.scl or negedge i_rst_async_n) begin
    if (!i_rst_async_n) begin
      sda_oe_n_reg <= 1'b1;
      rd_sh_reg <= 8'h00;
      stop_seen_reg <= 1'b0;
    end else begin
      stop_seen_reg <= stop_tgl_reg;
      if (stop_seen_reg != stop_tgl_reg) begin
        sda_oe_n_reg <= 1'b1; // RULE_11
      end else begin
        sda_oe_n_reg <= sda_oe_n_next; // RULE_02
      end
      if (bit_reg == 3'h7 || ack_phase_reg) begin
        rd_sh_reg <= rd_byte;
      end
    end
  end
  assign bus.slv_sda_oe_n = sda_oe_n_reg;

  // system domain: toggle crossing of write events and of start/stop framing
  logic [2:0] wtgl_sync_reg;
  logic [2:0] start_sync_reg;
  logic [2:0] stop_sync_reg;
  logic [1:0] rst_sync_reg;
  logic wr_pulse_next, busy_next;
  always_comb begin
    wr_pulse_next = wtgl_sync_reg[2] ^ wtgl_sync_reg[1];
    busy_next = o_busy;
    // the link clock stops after a stop, so busy is framed by the line conditions
    if (stop_sync_reg[2] ^ stop_sync_reg[1]) begin
      busy_next = 1'b0; // RULE_11
    end
    if (start_sync_reg[2] ^ start_sync_reg[1]) begin
      busy_next = 1'b1;
    end
  end
  // sync chains follow only the chip reset, which also clears the toggles,
  // so a plain i_rst cannot fake an edge
  always_ff @(posedge i_clk_sys) begin
    if (!rst_sync_reg[1]) begin
      wtgl_sync_reg <= 3'h0;
      start_sync_reg <= 3'h0;
      stop_sync_reg <= 3'h0;
    end else if (i_ce) begin
      wtgl_sync_reg <= {wtgl_sync_reg[1:0], wtgl_reg};
      start_sync_reg <= {start_sync_reg[1:0], start_tgl_reg};
      stop_sync_reg <= {stop_sync_reg[1:0], stop_tgl_reg};
    end
  end
  always_ff @(posedge i_clk_sys) begin
    rd_byte_sys <= (idx_reg == 8'hFF) ? i_status_data : regs[idx_reg];
    if (i_rst || !rst_sync_reg[1]) begin
      o_wr_pulse <= 1'b0;
      o_wr_index <= 8'h00;
      o_wr_data <= 8'h00;
      o_busy <= 1'b0;
      for (int i = 0; i < SRAS_REG_COUNT; i++) begin
        regs[i] <= SRAS_REG_RESET; // RULE_09
      end
    end else if (i_ce) begin
      o_busy <= busy_next;
      o_wr_pulse <= wr_pulse_next;
      if (wr_pulse_next) begin
        regs[widx_reg] <= wdat_reg; // RULE_05
        o_wr_index <= widx_reg;
        o_wr_data <= wdat_reg;
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_async_n) begin
    if (!i_rst_async_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
endmodule

// ### src/sras_pkg.sv
// constants shared by the serial register access slave and its bus master
// Operation
// RULE_01: serial clock never above 400 kHz
// RULE_02: slave drives data line only, clock input
// RULE_03: address is 100, sel1, 01, sel0, direction
// RULE_04: write: start, address, index, data, stop
// RULE_05: write data lands at index, then increments
// RULE_06: read: write index, then repeated start
// RULE_07: read returns index registers upward until stop
// RULE_08: answer only address matching select pins
// RULE_09: async low reset restores all defaults
// RULE_10: reserved registers written only with defaults; the slave stores any written value at any of its 256 indexes
// RULE_11: stop or start ends transfer cleanly
package sras_pkg;
  localparam logic [2:0] SRAS_ADDR_HI = 3'h4;
  localparam logic [1:0] SRAS_ADDR_MID = 2'h1;
  localparam int SRAS_REG_COUNT = 256;
  localparam logic [7:0] SRAS_REG_RESET = 8'h00;
  localparam int SRAS_SYS_CLK_KHZ = 10000;
  localparam int SRAS_SCL_MAX_KHZ = 400;
  // half period of the link clock, rounded up so the rate stays at or under the limit
  localparam int SRAS_SCL_HALF_CYC =
    (SRAS_SYS_CLK_KHZ + 2 * SRAS_SCL_MAX_KHZ - 1) / (2 * SRAS_SCL_MAX_KHZ);
  localparam logic [3:0] SRAS_HALF_LOAD = 4'(SRAS_SCL_HALF_CYC - 1);
  localparam logic [1:0] SRAS_RST_EDGES = 2'h3;
  typedef enum {SRAS_S_IDLE, SRAS_S_ADDR, SRAS_S_INDEX, SRAS_S_WDATA, SRAS_S_RDATA,
    SRAS_S_IGNORE} sras_state_t;
  typedef enum {SRAS_M_IDLE, SRAS_M_START, SRAS_M_BIT, SRAS_M_ACK, SRAS_M_STOP,
    SRAS_M_RSTART} sras_mstate_t;
endpackage

// ### src/sras_if.sv
// two-wire link between the register slave and its master
`timescale 1ns/10ps
interface sras_if;
  logic scl;
  logic sda_in;
  logic slv_sda_oe_n;
  logic mst_sda_oe_n;
  // open drain: line low when either end enables its driver
  assign sda_in = slv_sda_oe_n & mst_sda_oe_n;
  modport slave (input scl, input sda_in, output slv_sda_oe_n);
  modport master (output scl, input sda_in, output mst_sda_oe_n);
endinterface

// ### src/sras_master.sv
// bus master end: runs indexed writes and reads, makes the link clock by division
`timescale 1ns/10ps
module sras_master
  import sras_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_req,
  input wire logic i_read,
  input wire logic [1:0] i_sel,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_count,
  sras_if.master bus,
  output logic o_busy,
  output logic o_byte_valid,
  output logic [7:0] o_rdata,
  output logic o_nack
);
  sras_mstate_t st_reg, st_next;
  logic [3:0] div_reg, div_next;
  logic scl_reg, scl_next;
  logic oe_n_reg, oe_n_next;
  logic [7:0] sh_reg, sh_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] left_reg, left_next;
  logic rd_reg, rd_next;
  logic reread_reg, reread_next;
  logic [1:0] byte_no_reg, byte_no_next;
  logic [7:0] idx_reg, idx_next;
  logic [7:0] wd_reg, wd_next;
  logic valid_next, nack_next;
  logic [7:0] rdata_next;
  logic [1:0] sda_sync_reg;
  logic tick;
  logic [7:0] addr_w;

  assign tick = div_reg == 4'h0; // RULE_01
  assign addr_w = {SRAS_ADDR_HI, i_sel[1], SRAS_ADDR_MID, i_sel[0], 1'b0}; // RULE_03

  always_comb begin
    st_next = st_reg;
    div_next = tick ? SRAS_HALF_LOAD : div_reg - 4'h1;
    scl_next = scl_reg;
    oe_n_next = oe_n_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    phase_next = phase_reg;
    left_next = left_reg;
    rd_next = rd_reg;
    reread_next = reread_reg;
    byte_no_next = byte_no_reg;
    idx_next = idx_reg;
    wd_next = wd_reg;
    valid_next = 1'b0;
    nack_next = 1'b0;
    rdata_next = o_rdata;
    case (st_reg)
      SRAS_M_IDLE: begin
        scl_next = 1'b1;
        oe_n_next = 1'b1;
        if (i_req) begin
          st_next = SRAS_M_START;
          phase_next = 2'h0;
          rd_next = i_read;
          reread_next = 1'b0;
          left_next = i_count;
          idx_next = i_index;
          wd_next = i_wdata;
          div_next = SRAS_HALF_LOAD;
        end
      end
      SRAS_M_START, SRAS_M_RSTART: begin
        if (tick) begin
          phase_next = phase_reg + 2'h1;
          case (phase_reg)
            2'h0: begin
              scl_next = 1'b1;
              oe_n_next = 1'b1;
            end
            2'h1: oe_n_next = 1'b0; // RULE_04 RULE_06
            2'h2: scl_next = 1'b0;
            default: begin
              st_next = SRAS_M_BIT;
              sh_next = reread_reg ? (addr_w | 8'h01) : addr_w;
              byte_no_next = 2'h0;
              bit_next = 3'h7;
              phase_next = 2'h0;
            end
          endcase
        end
      end
      SRAS_M_BIT: begin
        if (tick) begin
          if (!scl_reg) begin
            oe_n_next = (reread_reg && byte_no_reg != 2'h0) ? 1'b1 : sh_reg[7];
            scl_next = phase_reg == 2'h1;
            phase_next = phase_reg == 2'h1 ? 2'h0 : 2'h1;
          end else begin
            scl_next = 1'b0;
            sh_next = {sh_reg[6:0], sda_sync_reg[1]};
            if (bit_reg == 3'h0) begin
              st_next = SRAS_M_ACK;
            end
            bit_next = bit_reg - 3'h1;
          end
        end
      end
      SRAS_M_ACK: begin
        if (tick) begin
          if (!scl_reg) begin
            if (phase_reg == 2'h0) begin
              // reader acks every byte but the last
              oe_n_next = !(reread_reg && byte_no_reg != 2'h0 && left_reg > 4'h1);
              phase_next = 2'h1;
            end else begin
              scl_next = 1'b1;
              phase_next = 2'h0;
            end
          end else begin
            scl_next = 1'b0;
            st_next = SRAS_M_BIT;
            bit_next = 3'h7;
            byte_no_next = byte_no_reg == 2'h2 ? 2'h2 : byte_no_reg + 2'h1;
            if (reread_reg && byte_no_reg != 2'h0) begin
              valid_next = 1'b1;
              rdata_next = sh_reg;
              left_next = left_reg - 4'h1;
              if (left_reg <= 4'h1) begin
                st_next = SRAS_M_STOP;
              end
            end else if (sda_sync_reg[1]) begin
              nack_next = 1'b1;
              st_next = SRAS_M_STOP;
            end else if (byte_no_reg == 2'h0) begin
              sh_next = idx_reg;
              if (reread_reg) begin
                sh_next = 8'hFF;
              end
            end else if (rd_reg) begin
              st_next = SRAS_M_RSTART; // RULE_06
              reread_next = 1'b1;
              phase_next = 2'h0;
            end else if (left_reg == 4'h0) begin
              st_next = SRAS_M_STOP;
            end else begin
              sh_next = wd_reg; // RULE_10
              wd_next = wd_reg + 8'h01;
              left_next = left_reg - 4'h1;
            end
            // an own ack is released in the next low phase, never as scl falls,
            // so the slave cannot see a false stop
          end
        end
      end
      SRAS_M_STOP: begin
        if (tick) begin
          phase_next = phase_reg + 2'h1;
          case (phase_reg)
            2'h0: oe_n_next = 1'b0;
            2'h1: scl_next = 1'b1;
            2'h2: oe_n_next = 1'b1;
            default: st_next = SRAS_M_IDLE;
          endcase
        end
      end
      default: st_next = SRAS_M_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg <= SRAS_M_IDLE;
      div_reg <= SRAS_HALF_LOAD;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      sh_reg <= 8'h00;
      bit_reg <= 3'h7;
      phase_reg <= 2'h0;
      left_reg <= 4'h0;
      rd_reg <= 1'b0;
      reread_reg <= 1'b0;
      byte_no_reg <= 2'h0;
      idx_reg <= 8'h00;
      wd_reg <= 8'h00;
      sda_sync_reg <= 2'h3;
      o_busy <= 1'b0;
      o_byte_valid <= 1'b0;
      o_rdata <= 8'h00;
      o_nack <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
      div_reg <= div_next;
      scl_reg <= scl_next;
      oe_n_reg <= oe_n_next;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      phase_reg <= phase_next;
      left_reg <= left_next;
      rd_reg <= rd_next;
      reread_reg <= reread_next;
      byte_no_reg <= byte_no_next;
      idx_reg <= idx_next;
      wd_reg <= wd_next;
      sda_sync_reg <= {sda_sync_reg[0], bus.sda_in};
      o_busy <= st_next != SRAS_M_IDLE;
      o_byte_valid <= valid_next;
      o_rdata <= rdata_next;
      o_nack <= nack_next;
    end
  end
  assign bus.scl = scl_reg;
  assign bus.mst_sda_oe_n = oe_n_reg;
endmodule

// ### sim/sras_assertions.sv
// wire-level checks on the two-wire link between master and register slave
`timescale 1ns/10ps
module sras_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic slv_sda_oe_n,
  input wire logic mst_sda_oe_n,
  input wire logic i_addr_select_low,
  input wire logic i_addr_select_high
);
  logic scl_reg, sda_reg, in_addr_reg, in_addr_next, rd_reg, rd_next, ok_reg, ok_next;
  logic [3:0] bit_reg, bit_next, hold_reg, hold_next;
  logic [7:0] shift_reg, shift_next;
  logic start_w, stop_w, rise_w;
  assign start_w = scl && scl_reg && sda_reg && !sda_in;
  assign stop_w = scl && scl_reg && !sda_reg && sda_in;
  assign rise_w = scl && !scl_reg;
  // byte tracker rebuilt from the wire, so no design internals are trusted
  always_comb begin
    bit_next = bit_reg;
    shift_next = shift_reg;
    in_addr_next = in_addr_reg;
    rd_next = rd_reg;
    ok_next = ok_reg;
    hold_next = (scl != scl_reg) ? 4'h0 : ((hold_reg == 4'hF) ? 4'hF : hold_reg + 4'h1);
    if (start_w || stop_w) begin
      bit_next = 4'h0;
      in_addr_next = 1'b1;
    end else if (rise_w) begin
      if (bit_reg == 4'h8) begin
        bit_next = 4'h0;
        in_addr_next = 1'b0;
        if (in_addr_reg) ok_next = !sda_in;
      end else begin
        shift_next = {shift_reg[6:0], sda_in};
        bit_next = bit_reg + 4'h1;
        if (in_addr_reg && bit_reg == 4'h7) rd_next = sda_in;
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      bit_reg <= 4'h0;
      hold_reg <= 4'hF;
      shift_reg <= 8'h00;
      in_addr_reg <= 1'b1;
      rd_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda_in;
      bit_reg <= bit_next;
      hold_reg <= hold_next;
      shift_reg <= shift_next;
      in_addr_reg <= in_addr_next;
      rd_reg <= rd_next;
      ok_reg <= ok_next;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_scl_hold; (scl != scl_reg) |-> (hold_reg >= 4'hA); endproperty
  property p_slv_edge; $changed(slv_sda_oe_n) |-> !scl; endproperty
  property p_addr_ack;
    rise_w && bit_reg == 4'h8 && in_addr_reg |->
      (!sda_in) == (shift_reg[7:1] == {3'h4, i_addr_select_high, 2'h1, i_addr_select_low});
  endproperty
  property p_data_ack;
    rise_w && bit_reg == 4'h8 && !in_addr_reg && !rd_reg && ok_reg |-> !sda_in;
  endproperty
  property p_rd_release; rise_w && bit_reg == 4'h8 && !in_addr_reg && rd_reg |-> slv_sda_oe_n; endproperty
  property p_wr_silent; rise_w && bit_reg != 4'h8 && (in_addr_reg || !rd_reg) |-> slv_sda_oe_n; endproperty
  property p_stop_quiet; stop_w |=> slv_sda_oe_n [*8]; endproperty
  property p_start_quiet; start_w |=> slv_sda_oe_n [*8]; endproperty
  property p_mst_sda; $changed(mst_sda_oe_n) && scl && scl_reg |-> start_w || stop_w; endproperty
  a_scl_hold: assert property (p_scl_hold) else $error("link clock phase too short");
  a_slv_edge: assert property (p_slv_edge) else $error("slave moved data while clock high");
  a_addr_ack: assert property (p_addr_ack) else $error("address ack does not follow straps");
  a_data_ack: assert property (p_data_ack) else $error("write byte not acknowledged");
  a_rd_release: assert property (p_rd_release) else $error("slave held line in read ack slot");
  a_wr_silent: assert property (p_wr_silent) else $error("slave drove line in master bits");
  a_stop_quiet: assert property (p_stop_quiet) else $error("slave drives after stop");
  a_start_quiet: assert property (p_start_quiet) else $error("slave drives after start");
  a_mst_sda: assert property (p_mst_sda) else $error("master moved data while clock high");
  c_write_ack: cover property (rise_w && bit_reg == 4'h8 && !in_addr_reg && !rd_reg && !sda_in);
  c_read_byte: cover property (rise_w && bit_reg == 4'h8 && !in_addr_reg && rd_reg);
  c_addr_nack: cover property (rise_w && bit_reg == 4'h8 && in_addr_reg && sda_in);
endmodule

// ### sim/sras_tb_top.sv
// testbench: master and register slave joined over the two-wire link
`timescale 1ns/10ps
module sras_tb_top;
  import sras_pkg::*;
  logic clk = 0, rst = 1, rst_n = 1, req = 0, rd = 0, sel_lo = 0, sel_hi = 1;
  logic [1:0] sel = 2'h0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] idx = 8'h00, wdata = 8'h00, status = 8'h00, w_idx, w_data, rdata;
  logic m_busy, s_busy, bvalid, nack, wr_pulse;
  int error_cnt = 0, total_checks = 0, nack_cnt = 0;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  sras_if link();
  sras_slave sras_slave_i (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_rst_async_n(rst_n),
    .i_addr_select_low(sel_lo), .i_addr_select_high(sel_hi), .i_status_data(status),
    .bus(link.slave), .o_wr_index(w_idx), .o_wr_data(w_data), .o_wr_pulse(wr_pulse),
    .o_busy(s_busy));
  sras_master sras_master_i (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_req(req),
    .i_read(rd), .i_sel(sel), .i_index(idx), .i_wdata(wdata), .i_count(cnt),
    .bus(link.master), .o_busy(m_busy), .o_byte_valid(bvalid), .o_rdata(rdata), .o_nack(nack));
  sras_assertions sras_assertions_i (.i_clk_sys(clk), .i_rst(rst), .scl(link.scl),
    .sda_in(link.sda_in), .slv_sda_oe_n(link.slv_sda_oe_n), .mst_sda_oe_n(link.mst_sda_oe_n),
    .i_addr_select_low(sel_lo), .i_addr_select_high(sel_hi));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_pulse === 1'b1) wq.push_back({w_idx, w_data});
    if (bvalid === 1'b1) rq.push_back(rdata);
    if (nack === 1'b1) nack_cnt++;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one whole transfer; busy must rise and fall within the bound
  task automatic xfer(input logic r, input logic [1:0] s, input logic [7:0] i,
    input logic [7:0] d, input logic [3:0] n);
    int k;
    bit seen;
    bit s_seen;
    wq.delete();
    rq.delete();
    nack_cnt = 0;
    seen = 0;
    s_seen = 0;
    @(posedge clk);
    rd <= r;
    sel <= s;
    idx <= i;
    wdata <= d;
    cnt <= n;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(posedge clk);
      #1;
      if (s_busy === 1'b1) s_seen = 1;
      if (m_busy === 1'b1) seen = 1;
      else if (seen) break;
    end
    // slave write events cross domains a few cycles late
    repeat (20) @(posedge clk);
    chk("transfer done", 16'h1, 16'(seen && m_busy === 1'b0));
    chk("slave busy framed", 16'h1, 16'(s_seen && s_busy === 1'b0));
  endtask
  task automatic s_write();
    xfer(1'b0, 2'h2, 8'h7E, 8'hA5, 4'h3);
    chk("write nack", 16'h0, 16'(nack_cnt));
    chk("write count", 16'h3, 16'(wq.size()));
    for (int k = 0; k < 3; k++) begin
      chk("write reg", {8'(8'h7E + k), 8'(8'hA5 + k)}, wq[k]);
    end
  endtask
  task automatic s_read();
    xfer(1'b1, 2'h2, 8'h7E, 8'h00, 4'h3);
    chk("read count", 16'h3, 16'(rq.size()));
    chk("read writes", 16'h0, 16'(wq.size()));
    for (int k = 0; k < 3; k++) begin
      chk("read reg", {8'h00, 8'(8'hA5 + k)}, {8'h00, rq[k]});
    end
    @(posedge clk);
    status <= 8'h3C;
    xfer(1'b1, 2'h2, 8'hFF, 8'h00, 4'h1);
    chk("status read", 16'h003C, {8'h00, rq[0]});
  endtask
  task automatic s_select();
    for (int s = 0; s < 4; s++) begin
      xfer(1'b0, 2'(s), 8'h10, 8'(8'h50 + s), 4'h1);
      chk("select writes", 16'(s == 2), 16'(wq.size()));
      chk("select nack", 16'(s != 2), 16'(nack_cnt != 0));
    end
    xfer(1'b1, 2'h2, 8'h10, 8'h00, 4'h1);
    chk("select reg", 16'h0052, {8'h00, rq[0]});
  endtask
  task automatic s_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    xfer(1'b1, 2'h2, 8'h7E, 8'h00, 4'h1);
    chk("reset reg", {8'h00, SRAS_REG_RESET}, {8'h00, rq[0]});
    xfer(1'b1, 2'h2, 8'h10, 8'h00, 4'h1);
    chk("reset reg", {8'h00, SRAS_REG_RESET}, {8'h00, rq[0]});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    // a real falling edge at time zero clears the link-clocked flops
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rst_n <= 1'b1;
    s_write();
    s_read();
    s_select();
    s_reset();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_of_test();
  end
endmodule
